// file: pkg/lsau_pkg.sv
package lsau_pkg;

  // ---------------------------------------------------------------------------
  // Widths and channel counts
  // ---------------------------------------------------------------------------
  localparam int REG_W = 8;
  localparam int ANA_W = 8;
  localparam int TACH_W = 16;
  localparam int ANA_COUNT = 5;
  localparam int FAN_COUNT = 4;
  localparam int DIODE_COUNT = 2;

  // Analog channel order on the measurement inputs.
  localparam int ANA_RAIL = 0;
  localparam int ANA_SUPPLY = 1;
  localparam int ANA_REMOTE_ONE = 2;
  localparam int ANA_LOCAL = 3;
  localparam int ANA_REMOTE_TWO = 4;
  // Temperatures are two's complement, voltages are unsigned codes.
  localparam logic [ANA_COUNT-1:0] ANA_SIGNED = 5'h1C;

  // Fan channel order on the tachometer inputs.
  localparam int FAN_ONE = 0;
  localparam int FAN_TWO = 1;
  localparam int FAN_THREE = 2;
  localparam int FAN_FOUR = 3;

  // ---------------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------------
  localparam logic [REG_W-1:0] STATUS_ONE_ADDR = 8'h41;
  localparam logic [REG_W-1:0] STATUS_TWO_ADDR = 8'h42;
  localparam logic [REG_W-1:0] ALERT_MASK_ONE_ADDR = 8'h74;
  localparam logic [REG_W-1:0] ALERT_MASK_TWO_ADDR = 8'h75;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int S1_SECOND_BANK_SUMMARY = 7;
  localparam int S1_REMOTE_TWO_TEMP_FLAG = 6;
  localparam int S1_LOCAL_TEMP_FLAG = 5;
  localparam int S1_REMOTE_ONE_TEMP_FLAG = 4;
  localparam int S1_SUPPLY_FLAG = 2;
  localparam int S1_RAIL_FLAG = 0;

  localparam int S2_DIODE_TWO_FAULT = 7;
  localparam int S2_DIODE_ONE_FAULT = 6;
  localparam int S2_FAN_FOUR_OR_TIMER_FLAG = 5;
  localparam int S2_FAN_THREE_SLOW = 4;
  localparam int S2_FAN_TWO_SLOW = 3;
  localparam int S2_FAN_ONE_SLOW = 2;
  localparam int S2_OVERTEMP_TRIP_FLAG = 1;

  // Implemented bits; everything else reads as zero and ignores writes, except status one bit 7, the summary.
  localparam logic [REG_W-1:0] STATUS_ONE_FLAGS = 8'h75;
  localparam logic [REG_W-1:0] STATUS_TWO_FLAGS = 8'hFE;
  localparam logic [REG_W-1:0] ALERT_MASK_ONE_USED = 8'hF5;
  localparam logic [REG_W-1:0] ALERT_MASK_TWO_USED = 8'hFE;

  // ---------------------------------------------------------------------------
  // Reset and idle values
  // ---------------------------------------------------------------------------
  localparam logic [REG_W-1:0] FLAGS_RESET = 8'h00;
  localparam logic [REG_W-1:0] ALERT_MASK_RESET = 8'h00;
  localparam logic [REG_W-1:0] READ_IDLE = 8'h00;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum {
    SEL_NONE,
    SEL_STATUS_ONE,
    SEL_STATUS_TWO,
    SEL_MASK_ONE,
    SEL_MASK_TWO
  } lsau_reg_sel_type;

  typedef struct packed {
    logic rdEn;
    logic wrEn;
    logic [REG_W-1:0] addr;
    logic [REG_W-1:0] wrData;
  } lsau_reg_req_type;

  typedef struct packed {
    logic [ANA_COUNT-1:0] valid;
    logic [ANA_COUNT-1:0][ANA_W-1:0] value;
    logic [ANA_COUNT-1:0][ANA_W-1:0] lowLimit;
    logic [ANA_COUNT-1:0][ANA_W-1:0] highLimit;
  } lsau_analog_type;

  typedef struct packed {
    logic [FAN_COUNT-1:0] valid;
    logic [FAN_COUNT-1:0][TACH_W-1:0] period;
    logic [FAN_COUNT-1:0][TACH_W-1:0] periodLimit;
  } lsau_tach_type;

  typedef struct packed {
    logic [DIODE_COUNT-1:0] diodeFault;
    logic overtempTrip;
    logic timerLimitExceeded;
    logic hotTripPinMode;
  } lsau_event_type;

endpackage

// file: design/lsau_limit_cmp.sv
`timescale 1ns/100ps
module lsau_limit_cmp #(
  parameter int WIDTH = 8,
  parameter bit SIGNED_CMP = 1'b0,
  parameter bit HAS_LOW = 1'b1
) (
  input wire logic [WIDTH-1:0] value,
  input wire logic [WIDTH-1:0] lowLimit,
  input wire logic [WIDTH-1:0] highLimit,
  output logic outOfLimit
);

  logic aboveHigh;
  logic atOrBelowLow;

  // ---------------------------------------------------------------------------
  // Comparison
  // ---------------------------------------------------------------------------
  // A reading equal to the high limit is still in range, one equal to the
  // low limit is already out of range.
  always_comb begin
    if (SIGNED_CMP) begin
      aboveHigh = $signed(value) > $signed(highLimit); // [R19]
      atOrBelowLow = $signed(value) <= $signed(lowLimit); // [R19]
    end else begin
      aboveHigh = value > highLimit; // [R19]
      atOrBelowLow = value <= lowLimit; // [R19]
    end
    outOfLimit = aboveHigh | (HAS_LOW & atOrBelowLow);
  end

endmodule

// file: design/lsau_top.sv
// Notes on behaviour
// [R1] A failed limit comparison sets that channel's status flag.
// [R2] Status one bit 7 reads 1 while any status two flag is set.
// [R3] Flags are sticky; only a status register read can clear them.
// [R4] A read clears a flag only if its condition has gone away.
// [R5] Alert stays low while unmasked source out of limit, then until read.
// [R6] Status one: remote-2 bit 6, local 5, remote-1 4, supply 2, rail 0.
// [R7] Status two bit 7 diode-2 fault, bit 6 diode-1 fault.
// [R8] Status two bits 4, 3, 2 flag fans 3, 2, 1 too slow.
// [R9] Status two bit 5 flags fan 4 slow, or timer limit in trip mode.
// [R10] Status two bit 1 flags overtemperature trip; bit 0 unused.
// [R11] Mask one bit 7 keeps all status two sources off the alert.
// [R12] Mask one bits 6, 5, 4, 2, 0 mask the matching status one sources.
// [R13] Mask two bits 7..1 mask diodes, fans 4..1 and overtemperature.
// [R14] In trip-pin mode mask two bit 5 masks timer events instead.
// [R15] Masks gate only the alert; status flags still set.
// [R16] Alert function is offered on a pin output for the supervisor.
// [R17] Host polls or reacts to alert by reading status registers.
// [R18] Host masks offending source, polls, unmasks after flag clears.
// [R19] High limit fails when strictly greater, low when less or equal.
// [R20] Alert output stays disabled after reset until enabled.
// [R21] Unused status and mask bits read zero and ignore writes.
// [R22] Alert is active-low open-drain, released when nothing unmasked pends.
`timescale 1ns/100ps
module lsau_top (
  input wire logic clk,
  input wire logic sys_rst,
  input lsau_pkg::lsau_reg_req_type regReq,
  output logic [lsau_pkg::REG_W-1:0] regRdData,
  output logic regRdValid,
  input lsau_pkg::lsau_analog_type analog,
  input lsau_pkg::lsau_tach_type tach,
  input lsau_pkg::lsau_event_type events,
  input wire logic alertEnable,
  output logic alertOutN,
  output logic alertOe
);
  import lsau_pkg::*;

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  lsau_reg_sel_type regSel;
  logic [ANA_COUNT-1:0] anaFail;
  logic [FAN_COUNT-1:0] fanFail;
  logic [ANA_COUNT-1:0] anaCond_q;
  logic [FAN_COUNT-1:0] fanCond_q;
  logic [ANA_COUNT-1:0] anaCondNow;
  logic [FAN_COUNT-1:0] fanCondNow;
  logic [REG_W-1:0] oneSet;
  logic [REG_W-1:0] oneCond;
  logic [REG_W-1:0] twoSet;
  logic [REG_W-1:0] twoCond;
  logic [REG_W-1:0] statusOne_q;
  logic [REG_W-1:0] statusOne_d;
  logic [REG_W-1:0] statusTwo_q;
  logic [REG_W-1:0] statusTwo_d;
  logic [REG_W-1:0] alertMaskOne_q;
  logic [REG_W-1:0] alertMaskTwo_q;
  logic [REG_W-1:0] statusOneView;
  logic readOne;
  logic readTwo;
  logic writeMaskOne;
  logic writeMaskTwo;
  logic secondBankSummary;
  logic onePending;
  logic twoPending;
  logic [REG_W-1:0] oneAlertSrc;
  logic [REG_W-1:0] twoAlertSrc;
  logic alertDrive_d;
  logic [REG_W-1:0] regRdData_d;
  logic alertOe_q;
  logic alertOutN_q;
  logic [REG_W-1:0] regRdData_q;
  logic regRdValid_q;

  // ---------------------------------------------------------------------------
  // Limit comparators
  // ---------------------------------------------------------------------------
  for (genvar i = 0; i < ANA_COUNT; i++) begin : gAna
    lsau_limit_cmp #(
      .WIDTH(ANA_W),
      .SIGNED_CMP(ANA_SIGNED[i]),
      .HAS_LOW(1'b1)
    ) uCmp (
      .value(analog.value[i]),
      .lowLimit(analog.lowLimit[i]),
      .highLimit(analog.highLimit[i]),
      .outOfLimit(anaFail[i])
    );
  end

  // A tach period above its limit means a slow or stalled fan; no low limit.
  for (genvar i = 0; i < FAN_COUNT; i++) begin : gFan
    lsau_limit_cmp #(
      .WIDTH(TACH_W),
      .SIGNED_CMP(1'b0),
      .HAS_LOW(1'b0)
    ) uCmp (
      .value(tach.period[i]),
      .lowLimit('0),
      .highLimit(tach.periodLimit[i]),
      .outOfLimit(fanFail[i])
    );
  end

  // ---------------------------------------------------------------------------
  // Last comparison result per channel
  // ---------------------------------------------------------------------------
  // The condition of a measured channel only changes when a new result
  // arrives, so the last verdict is held between measurements.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      anaCond_q <= '0;
    end else begin
      for (int i = 0; i < ANA_COUNT; i++) begin
        if (analog.valid[i]) begin
          anaCond_q[i] <= anaFail[i];
        end
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fanCond_q <= '0;
    end else begin
      for (int i = 0; i < FAN_COUNT; i++) begin
        if (tach.valid[i]) begin
          fanCond_q[i] <= fanFail[i];
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < ANA_COUNT; i++) begin
      anaCondNow[i] = analog.valid[i] ? anaFail[i] : anaCond_q[i];
    end
    for (int i = 0; i < FAN_COUNT; i++) begin
      fanCondNow[i] = tach.valid[i] ? fanFail[i] : fanCond_q[i];
    end
  end

  // ---------------------------------------------------------------------------
  // Flag set events and live conditions
  // ---------------------------------------------------------------------------
  always_comb begin
    oneSet = '0;
    oneCond = '0;
    twoSet = '0;
    twoCond = '0;
    oneSet[S1_REMOTE_TWO_TEMP_FLAG] = analog.valid[ANA_REMOTE_TWO] &
      anaFail[ANA_REMOTE_TWO]; // [R1] [R6]
    oneSet[S1_LOCAL_TEMP_FLAG] = analog.valid[ANA_LOCAL] & anaFail[ANA_LOCAL]; // [R1] [R6]
    oneSet[S1_REMOTE_ONE_TEMP_FLAG] = analog.valid[ANA_REMOTE_ONE] &
      anaFail[ANA_REMOTE_ONE]; // [R1] [R6]
    oneSet[S1_SUPPLY_FLAG] = analog.valid[ANA_SUPPLY] & anaFail[ANA_SUPPLY]; // [R1] [R6]
    oneSet[S1_RAIL_FLAG] = analog.valid[ANA_RAIL] & anaFail[ANA_RAIL]; // [R1] [R6]
    oneCond[S1_REMOTE_TWO_TEMP_FLAG] = anaCondNow[ANA_REMOTE_TWO];
    oneCond[S1_LOCAL_TEMP_FLAG] = anaCondNow[ANA_LOCAL];
    oneCond[S1_REMOTE_ONE_TEMP_FLAG] = anaCondNow[ANA_REMOTE_ONE];
    oneCond[S1_SUPPLY_FLAG] = anaCondNow[ANA_SUPPLY];
    oneCond[S1_RAIL_FLAG] = anaCondNow[ANA_RAIL];

    // Diode faults and the trip input are levels, present every cycle.
    twoSet[S2_DIODE_TWO_FAULT] = events.diodeFault[1]; // [R7]
    twoSet[S2_DIODE_ONE_FAULT] = events.diodeFault[0]; // [R7]
    twoCond[S2_DIODE_TWO_FAULT] = events.diodeFault[1];
    twoCond[S2_DIODE_ONE_FAULT] = events.diodeFault[0];
    if (events.hotTripPinMode) begin
      twoSet[S2_FAN_FOUR_OR_TIMER_FLAG] = events.timerLimitExceeded; // [R9] [R14]
      twoCond[S2_FAN_FOUR_OR_TIMER_FLAG] = events.timerLimitExceeded; // [R14]
    end else begin
      twoSet[S2_FAN_FOUR_OR_TIMER_FLAG] = tach.valid[FAN_FOUR] & fanFail[FAN_FOUR]; // [R9]
      twoCond[S2_FAN_FOUR_OR_TIMER_FLAG] = fanCondNow[FAN_FOUR];
    end
    twoSet[S2_FAN_THREE_SLOW] = tach.valid[FAN_THREE] & fanFail[FAN_THREE]; // [R8]
    twoSet[S2_FAN_TWO_SLOW] = tach.valid[FAN_TWO] & fanFail[FAN_TWO]; // [R8]
    twoSet[S2_FAN_ONE_SLOW] = tach.valid[FAN_ONE] & fanFail[FAN_ONE]; // [R8]
    twoCond[S2_FAN_THREE_SLOW] = fanCondNow[FAN_THREE];
    twoCond[S2_FAN_TWO_SLOW] = fanCondNow[FAN_TWO];
    twoCond[S2_FAN_ONE_SLOW] = fanCondNow[FAN_ONE];
    twoSet[S2_OVERTEMP_TRIP_FLAG] = events.overtempTrip; // [R10]
    twoCond[S2_OVERTEMP_TRIP_FLAG] = events.overtempTrip; // [R10]
  end

  // ---------------------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------------------
  always_comb begin
    case (regReq.addr)
      STATUS_ONE_ADDR: begin
        regSel = SEL_STATUS_ONE;
      end
      STATUS_TWO_ADDR: begin
        regSel = SEL_STATUS_TWO;
      end
      ALERT_MASK_ONE_ADDR: begin
        regSel = SEL_MASK_ONE;
      end
      ALERT_MASK_TWO_ADDR: begin
        regSel = SEL_MASK_TWO;
      end
      default: begin
        regSel = SEL_NONE;
      end
    endcase
  end

  assign readOne = regReq.rdEn && (regSel == SEL_STATUS_ONE);
  assign readTwo = regReq.rdEn && (regSel == SEL_STATUS_TWO);
  // Writes to the status registers find no strobe here and are dropped.
  assign writeMaskOne = regReq.wrEn && (regSel == SEL_MASK_ONE);
  assign writeMaskTwo = regReq.wrEn && (regSel == SEL_MASK_TWO);

  // ---------------------------------------------------------------------------
  // Sticky status flags
  // ---------------------------------------------------------------------------
  // A read drops only flags whose condition is gone; a new failure in the
  // same cycle as the read keeps its flag, so no event is lost.
  always_comb begin
    statusOne_d = statusOne_q;
    statusTwo_d = statusTwo_q;
    if (readOne) begin
      statusOne_d = statusOne_q & oneCond; // [R3] [R4]
    end
    if (readTwo) begin
      statusTwo_d = statusTwo_q & twoCond; // [R3] [R4]
    end
    statusOne_d = (statusOne_d | oneSet) & STATUS_ONE_FLAGS; // [R1] [R15] [R21]
    statusTwo_d = (statusTwo_d | twoSet) & STATUS_TWO_FLAGS; // [R15] [R21]
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      statusOne_q <= FLAGS_RESET;
      statusTwo_q <= FLAGS_RESET;
    end else begin
      statusOne_q <= statusOne_d;
      statusTwo_q <= statusTwo_d;
    end
  end

  // Bit 7 is not stored: it follows status two, so it drops with the very
  // read that empties status two and can never disagree with it.
  always_comb begin
    secondBankSummary = |statusTwo_q; // [R2]
    statusOneView = statusOne_q;
    statusOneView[S1_SECOND_BANK_SUMMARY] = secondBankSummary; // [R2]
  end

  // ---------------------------------------------------------------------------
  // Alert masks
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      alertMaskOne_q <= ALERT_MASK_RESET;
      alertMaskTwo_q <= ALERT_MASK_RESET;
    end else begin
      if (writeMaskOne) begin
        alertMaskOne_q <= regReq.wrData & ALERT_MASK_ONE_USED; // [R12] [R21]
      end
      if (writeMaskTwo) begin
        alertMaskTwo_q <= regReq.wrData & ALERT_MASK_TWO_USED; // [R13] [R21]
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------------------
  // Data are captured at the same edge that clears flags, so the host sees
  // the flags as they stood before its own read.
  always_comb begin
    case (regSel)
      SEL_STATUS_ONE: begin
        regRdData_d = statusOneView;
      end
      SEL_STATUS_TWO: begin
        regRdData_d = statusTwo_q;
      end
      SEL_MASK_ONE: begin
        regRdData_d = alertMaskOne_q;
      end
      SEL_MASK_TWO: begin
        regRdData_d = alertMaskTwo_q;
      end
      default: begin
        regRdData_d = READ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdValid_q <= 1'b0;
    end else begin
      regRdValid_q <= regReq.rdEn;
    end
  end

  // Read data hold between reads, so a slow host may pick them up late.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdData_q <= READ_IDLE;
    end else if (regReq.rdEn) begin
      regRdData_q <= regRdData_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Alert output
  // ---------------------------------------------------------------------------
  // Live conditions are included beside the flags so the alert follows a
  // failure in the very cycle its flag is set, not one cycle later.
  // The enable gates only the pin; flags keep collecting while it is low, so
  // turning the alert on later still reports what happened meanwhile.
  always_comb begin
    oneAlertSrc = (statusOne_q | oneCond) & ~alertMaskOne_q & STATUS_ONE_FLAGS; // [R5] [R12]
    twoAlertSrc = (statusTwo_q | twoCond) & ~alertMaskTwo_q & STATUS_TWO_FLAGS; // [R13] [R14]
    onePending = |oneAlertSrc;
    twoPending = (|twoAlertSrc) & ~alertMaskOne_q[S1_SECOND_BANK_SUMMARY]; // [R11]
    alertDrive_d = alertEnable & (onePending | twoPending); // [R5] [R20]
  end

  // The pin is only ever pulled low; the board pull-up makes the high level.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      alertOe_q <= 1'b0;
      alertOutN_q <= 1'b1;
    end else begin
      alertOe_q <= alertDrive_d; // [R16] [R22]
      alertOutN_q <= ~alertDrive_d; // [R22]
    end
  end

  assign alertOe = alertOe_q;
  assign alertOutN = alertOutN_q;
  assign regRdData = regRdData_q;
  assign regRdValid = regRdValid_q;

endmodule

// file: tb/lsau_asserts.sv
`timescale 1ns/100ps
module lsau_asserts (
  input wire logic clk,
  input wire logic sys_rst,
  input lsau_pkg::lsau_reg_req_type regReq,
  input wire logic [lsau_pkg::REG_W-1:0] regRdData,
  input wire logic regRdValid,
  input lsau_pkg::lsau_analog_type analog,
  input lsau_pkg::lsau_event_type events,
  input wire logic alertEnable,
  input wire logic alertOutN,
  input wire logic alertOe
);
  import lsau_pkg::*;
  // ----------------------------------------
  // Shadow state
  // ----------------------------------------
  logic [REG_W-1:0] maskOne_q;
  logic [REG_W-1:0] readUsed_q;
  logic diodePrev_q;
  logic localFail;

  // Mask one is shadowed from the write port, since the checker cannot see inside.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      maskOne_q <= ALERT_MASK_RESET;
    end else if (regReq.wrEn && regReq.addr == ALERT_MASK_ONE_ADDR) begin
      maskOne_q <= regReq.wrData & ALERT_MASK_ONE_USED;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      readUsed_q <= READ_IDLE;
    end else if (regReq.rdEn) begin
      readUsed_q <= (regReq.addr == STATUS_ONE_ADDR || regReq.addr == ALERT_MASK_ONE_ADDR) ?
        ALERT_MASK_ONE_USED : (regReq.addr == STATUS_TWO_ADDR ||
        regReq.addr == ALERT_MASK_TWO_ADDR) ? ALERT_MASK_TWO_USED : READ_IDLE;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      diodePrev_q <= 1'b0;
    end else begin
      diodePrev_q <= events.diodeFault[1];
    end
  end

  assign localFail = analog.valid[ANA_LOCAL] &&
    ($signed(analog.value[ANA_LOCAL]) > $signed(analog.highLimit[ANA_LOCAL]) ||
    $signed(analog.value[ANA_LOCAL]) <= $signed(analog.lowLimit[ANA_LOCAL]));

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  read_answer_a: assert property (regReq.rdEn |=> regRdValid)
    else $error("read request got no valid data");
  open_drain_a: assert property (alertOe == !alertOutN)
    else $error("alert enable and level disagree");
  alert_off_a: assert property (!alertEnable |=> !alertOe)
    else $error("alert driven while disabled");
  local_alert_a: assert property (localFail && alertEnable &&
    !maskOne_q[S1_LOCAL_TEMP_FLAG] |=> alertOe)
    else $error("unmasked local failure did not drive alert");
  alert_hold_a: assert property (alertOe && alertEnable && !(regReq.rdEn || regReq.wrEn ||
    $past(regReq.rdEn) || $past(regReq.wrEn)) |=> alertOe)
    else $error("alert released without a read");
  diode_flag_a: assert property (diodePrev_q && regReq.rdEn &&
    regReq.addr == STATUS_TWO_ADDR |=> regRdData[S2_DIODE_TWO_FAULT])
    else $error("diode two fault not flagged");
  summary_bit_a: assert property (diodePrev_q && regReq.rdEn &&
    regReq.addr == STATUS_ONE_ADDR |=> regRdData[S1_SECOND_BANK_SUMMARY])
    else $error("summary bit missing");
  unused_zero_a: assert property (regRdValid |-> (regRdData & ~readUsed_q) == READ_IDLE)
    else $error("unused bit read as one");
  mask_readback_a: assert property (regRdValid &&
    $past(regReq.addr) == ALERT_MASK_ONE_ADDR |-> regRdData == $past(maskOne_q))
    else $error("mask one read back wrong");
endmodule

bind lsau_top lsau_asserts lsauChk (.clk, .sys_rst, .regReq, .regRdData, .regRdValid,
  .analog, .events, .alertEnable, .alertOutN, .alertOe);

// file: tb/lsau_host_model.sv
`timescale 1ns/100ps
module lsau_host_model (
  input wire logic clk,
  input wire logic alertOe,
  input wire logic alertOutN,
  input wire logic [lsau_pkg::REG_W-1:0] regRdData,
  input wire logic regRdValid,
  output lsau_pkg::lsau_reg_req_type regReq,
  output logic alertLine
);
  import lsau_pkg::*;
  // The alert wire has a pull-up, so a released pin reads high.
  assign alertLine = alertOe ? alertOutN : 1'b1;

  initial regReq = '0;

  // Status is polled or fetched after an alert, one access at a time.
  task automatic regWrite(input logic [REG_W-1:0] addr, input logic [REG_W-1:0] data);
    @(posedge clk);
    regReq.wrEn <= 1'b1;
    regReq.addr <= addr;
    regReq.wrData <= data;
    @(posedge clk);
    regReq.wrEn <= 1'b0;
    regReq.addr <= ~addr;
    regReq.wrData <= ~data;
  endtask

  task automatic regRead(input logic [REG_W-1:0] addr, output logic [REG_W-1:0] data,
      output logic ok);
    @(posedge clk);
    regReq.rdEn <= 1'b1;
    regReq.addr <= addr;
    @(posedge clk);
    regReq.rdEn <= 1'b0;
    regReq.addr <= ~addr;
    #1;
    ok = regRdValid;
    data = regRdData;
  endtask
endmodule

// file: tb/test_limit_status_alert_unit.sv
`timescale 1ns/100ps
module test_limit_status_alert_unit;
  import lsau_pkg::*;
  logic clk;
  logic sys_rst;
  lsau_reg_req_type regReq;
  logic [REG_W-1:0] regRdData;
  logic regRdValid;
  lsau_analog_type analog;
  lsau_tach_type tach;
  lsau_event_type events;
  logic alertEnable;
  logic alertOutN;
  logic alertOe;
  logic alertLine;
  int nFail;
  int nCompared;
  int seed;
  int ch;
  int b;
  int b2;
  logic [REG_W-1:0] rd;
  logic [REG_W-1:0] m1;
  logic [REG_W-1:0] m2;
  logic [REG_W-1:0] v;
  logic [REG_W-1:0] lo;
  logic [REG_W-1:0] hi;
  logic [REG_W-1:0] bitMask;
  logic en;
  logic [REG_W-1:0] addrs [5];

  lsau_top dut (.clk(clk), .sys_rst(sys_rst), .regReq(regReq), .regRdData(regRdData),
    .regRdValid(regRdValid), .analog(analog), .tach(tach), .events(events),
    .alertEnable(alertEnable), .alertOutN(alertOutN), .alertOe(alertOe));
  lsau_host_model host (.clk(clk), .alertOe(alertOe), .alertOutN(alertOutN),
    .regRdData(regRdData), .regRdValid(regRdValid), .regReq(regReq), .alertLine(alertLine));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ----------------------------------------
  // Expectations and checks
  // ----------------------------------------
  function automatic logic anaFail(int c, logic [7:0] x, logic [7:0] l, logic [7:0] h);
    if (ANA_SIGNED[c]) return $signed(x) > $signed(h) || $signed(x) <= $signed(l);
    return x > h || x <= l;
  endfunction

  function automatic int s1Bit(int c);
    return (c == 0) ? 0 : (c == 1) ? 2 : c + 2;
  endfunction

  task automatic check(string name, logic [7:0] exp, logic [7:0] got);
    nCompared++;
    if (got !== exp) begin
      nFail++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic readCheck(logic [7:0] addr, logic [7:0] exp, string name);
    logic ok;
    host.regRead(addr, rd, ok);
    check("read valid", 8'h01, {7'h00, ok});
    check(name, exp, rd);
  endtask

  task automatic measure(int c, logic [7:0] x);
    @(posedge clk);
    analog.value[c] <= x;
    analog.lowLimit[c] <= lo;
    analog.highLimit[c] <= hi;
    analog.valid[c] <= 1'b1;
    @(posedge clk);
    analog.valid <= '0;
    #1;
  endtask

  // Fans sit exactly on the limit when idle, the in-limit boundary.
  task automatic setSource(int s, logic on);
    @(posedge clk);
    events.hotTripPinMode <= (s == 8);
    case (s)
      7: events.diodeFault[1] <= on;
      6: events.diodeFault[0] <= on;
      8: events.timerLimitExceeded <= on;
      1: events.overtempTrip <= on;
      default: begin
        tach.periodLimit[s-2] <= 16'h4000;
        tach.period[s-2] <= on ? 16'h4001 : 16'h4000;
        tach.valid[s-2] <= 1'b1;
      end
    endcase
    @(posedge clk);
    tach.valid <= '0;
    @(posedge clk);
    #1;
  endtask

  task automatic results;
    $display("compared %0d failed %0d", nCompared, nFail);
    if (nFail == 0 && nCompared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    nFail++;
    results();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed = 32'h2d2a;
    nFail = 0;
    nCompared = 0;
    sys_rst = 1'b1;
    analog = '0;
    tach = '0;
    events = '0;
    alertEnable = 1'b0;
    addrs = '{STATUS_ONE_ADDR, STATUS_TWO_ADDR, ALERT_MASK_ONE_ADDR, ALERT_MASK_TWO_ADDR, 8'h10};
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      readCheck(addrs[i], 8'h00, "reset value");
      check("alert idle", 8'h01, {7'h00, alertLine});
      v = 8'($random(seed));
      host.regWrite(addrs[i], v);
      readCheck(addrs[i], (i == 2) ? v & 8'hF5 : (i == 3) ? v & 8'hFE : 8'h00, "write");
    end
    @(posedge clk);
    alertEnable <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      ch = i % ANA_COUNT;
      lo = ANA_SIGNED[ch] ? 8'hF8 : 8'h10;
      hi = ANA_SIGNED[ch] ? 8'h20 : 8'hC0;
      case (i / ANA_COUNT)
        0: v = lo;
        1: v = hi;
        2: v = hi + 8'h01;
        3: v = 8'hFC;
        default: v = 8'($random(seed));
      endcase
      m1 = 8'($random(seed));
      host.regWrite(ALERT_MASK_ONE_ADDR, m1);
      bitMask = {7'h00, anaFail(ch, v, lo, hi)} << s1Bit(ch);
      measure(ch, v);
      check("alert", {7'h00, !(bitMask != 8'h00 && !m1[s1Bit(ch)])}, {7'h00, alertLine});
      readCheck(STATUS_ONE_ADDR, bitMask, "status one");
      readCheck(STATUS_ONE_ADDR, bitMask, "status one held");
      measure(ch, hi);
      readCheck(STATUS_ONE_ADDR, bitMask, "status one sticky");
      readCheck(STATUS_ONE_ADDR, 8'h00, "status one clear");
      @(posedge clk);
      #1;
      check("alert released", 8'h01, {7'h00, alertLine});
    end
    for (int i = 0; i < 24; i++) begin
      b = i % 8 + 1;
      b2 = (b == 8) ? 5 : b;
      m1 = 8'($random(seed));
      m2 = 8'($random(seed));
      en = 1'($random(seed));
      host.regWrite(ALERT_MASK_ONE_ADDR, m1);
      host.regWrite(ALERT_MASK_TWO_ADDR, m2);
      alertEnable <= en;
      setSource(b, 1'b1);
      v = {7'h00, !(en && !m1[7] && !m2[b2])};
      check("alert", v, {7'h00, alertLine});
      readCheck(STATUS_ONE_ADDR, 8'h80, "summary");
      bitMask = 8'h01 << b2;
      readCheck(STATUS_TWO_ADDR, bitMask, "status two");
      host.regWrite(ALERT_MASK_TWO_ADDR, bitMask);
      @(posedge clk);
      #1;
      check("alert masked", 8'h01, {7'h00, alertLine});
      setSource(b, 1'b0);
      readCheck(STATUS_TWO_ADDR, bitMask, "status two sticky");
      readCheck(STATUS_TWO_ADDR, 8'h00, "status two clear");
      readCheck(STATUS_ONE_ADDR, 8'h00, "summary clear");
      host.regWrite(ALERT_MASK_TWO_ADDR, 8'h00);
      @(posedge clk);
      #1;
      check("alert unmasked", 8'h01, {7'h00, alertLine});
    end
    results();
  end
endmodule
